// ===== inc/ncp_pkg.sv
// Package of offsets, field positions, reset values and timing for the pointer/config block
package ncp_pkg;

  // ==========================================================================
  // Bus and memory geometry
  localparam int unsigned NCP_WB_AW   = 8;
  localparam int unsigned NCP_WB_DW   = 32;
  localparam int unsigned NCP_RAM_AW  = 11;
  localparam int unsigned NCP_RAM_DW  = 8;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] NCP_ADR_DATA   = 8'h00;
  localparam logic [7:0] NCP_ADR_PTR_HI = 8'h04;
  localparam logic [7:0] NCP_ADR_PTR_LO = 8'h08;
  localparam logic [7:0] NCP_ADR_SEL    = 8'h0c;
  localparam logic [7:0] NCP_ADR_CFG    = 8'h10;
  localparam logic [7:0] NCP_ADR_IND    = 8'h14;
  localparam logic [7:0] NCP_ADR_STAT   = 8'h18;
  localparam logic [7:0] NCP_ADR_DIAG   = 8'h1c;

  // ==========================================================================
  // Pointer high fields
  localparam int unsigned NCP_PH_READ   = 7;
  localparam int unsigned NCP_PH_STEP   = 6;
  localparam int unsigned NCP_PH_UP_MSB = 2;

  // ==========================================================================
  // Configuration fields
  localparam int unsigned NCP_CF_SRST   = 7;
  localparam int unsigned NCP_CF_CHAIN  = 6;
  localparam int unsigned NCP_CF_TX_DRIVE_ENABLE   = 5;
  localparam int unsigned NCP_CF_ET_MSB = 4;
  localparam int unsigned NCP_CF_ET_LSB = 3;
  localparam int unsigned NCP_CF_LDRV   = 2;
  localparam int unsigned NCP_SEL_MSB   = 2;

  // ==========================================================================
  // Indirect select codes
  localparam logic [2:0] NCP_IND_TENT  = 3'h0;
  localparam logic [2:0] NCP_IND_NODE  = 3'h1;
  localparam logic [2:0] NCP_IND_SET1  = 3'h2;
  localparam logic [2:0] NCP_IND_NEXT  = 3'h3;
  localparam logic [2:0] NCP_IND_SET2  = 3'h4;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] NCP_BYTE_RST = 8'h00;
  localparam logic [10:0] NCP_PTR_RST = 11'h000;

  // ==========================================================================
  // Response times per extended timeout code
  localparam int unsigned NCP_CLK_MHZ     = 200;
  localparam int unsigned NCP_RESP_NS_0   = 596600;
  localparam int unsigned NCP_RESP_NS_1   = 298400;
  localparam int unsigned NCP_RESP_NS_2   = 149200;
  localparam int unsigned NCP_RESP_NS_3   = 37400;
  localparam int unsigned NCP_RESP_W      = 17;
  localparam int unsigned NCP_RESP_CYC_0  = NCP_RESP_NS_0 * NCP_CLK_MHZ / 1000;
  localparam int unsigned NCP_RESP_CYC_1  = NCP_RESP_NS_1 * NCP_CLK_MHZ / 1000;
  localparam int unsigned NCP_RESP_CYC_2  = NCP_RESP_NS_2 * NCP_CLK_MHZ / 1000;
  localparam int unsigned NCP_RESP_CYC_3  = NCP_RESP_NS_3 * NCP_CLK_MHZ / 1000;

  // ==========================================================================
  // Prefetch sequencer
  typedef enum logic [1:0] {
    NCP_FETCH_IDLE,
    NCP_FETCH_ISSUE,
    NCP_FETCH_CATCH
  } ncp_fetch_t;

endpackage

// ===== src/ncp_ram.sv
// Single-port packet memory with registered read data
module ncp_ram #(
  parameter int unsigned AW = 11,
  parameter int unsigned DW = 8
) (
  // Clock
  input  wire logic          clk_i,
  // Access port
  input  wire logic          we_i,
  input  wire logic          rd_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [2**AW];

  // ==========================================================================
  // Storage; read data only moves when a read is asked for
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    if (rd_i) begin
      rdata_o <= mem[addr_i];
    end
  end

endmodule

// ===== src/ncp_regs.sv
// Pointer, indirect select and configuration registers with packet RAM access
//
// Overview of operation
// - Pointer high bit 7 picks next data access direction, one read, zero write.
// - Pointer high bit 6 set advances the RAM pointer after each data access.
// - RAM address is pointer high bits 2-0 over pointer low bits 7-0.
// - Three-bit select picks the indirect register; codes five to seven reserved.
// - Two low select bits are one store, seen in select and configuration.
// - Any configuration write clears the top select bit.
// - Configuration bit 7 holds software reset until written back to zero.
// - Software reset clears only status, next identifier and diagnostic status.
// - Configuration bit 6 enables command chaining; low keeps legacy behaviour.
// - Transmit enable low holds pulse A and driver pins inactive, and pulse B unless line-driver mode is set; resets low.
// - Extended timeout field picks one of four response times.
// - Configuration bit 2 selects line-driver signalling instead of hybrid.
//
// Implementation choices: the Wishbone register port and the address map.
module ncp_regs
  import ncp_pkg::*;
#(
  parameter logic [ncp_pkg::NCP_RESP_W-1:0] RESP_CYC_0 =
    ncp_pkg::NCP_RESP_W'(ncp_pkg::NCP_RESP_CYC_0),
  parameter logic [ncp_pkg::NCP_RESP_W-1:0] RESP_CYC_1 =
    ncp_pkg::NCP_RESP_W'(ncp_pkg::NCP_RESP_CYC_1),
  parameter logic [ncp_pkg::NCP_RESP_W-1:0] RESP_CYC_2 =
    ncp_pkg::NCP_RESP_W'(ncp_pkg::NCP_RESP_CYC_2),
  parameter logic [ncp_pkg::NCP_RESP_W-1:0] RESP_CYC_3 =
    ncp_pkg::NCP_RESP_W'(ncp_pkg::NCP_RESP_CYC_3)
) (
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  // Wishbone slave
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [ncp_pkg::NCP_WB_AW-1:0]     wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [ncp_pkg::NCP_WB_DW-1:0]     wb_dat_i,
  output logic      [ncp_pkg::NCP_WB_DW-1:0]     wb_dat_o,
  output logic                                   wb_ack_o,
  // Protocol engine side
  input  wire logic                              tx_pulse_a_i,
  input  wire logic                              tx_pulse_b_i,
  input  wire logic                              tx_drive_i,
  input  wire logic                              next_id_load_i,
  input  wire logic [7:0]                        next_id_i,
  input  wire logic [7:0]                        status_i,
  input  wire logic [7:0]                        diag_i,
  output logic                                   soft_reset_o,
  output logic                                   cmd_chain_enable_o,
  output logic                                   line_driver_mode_o,
  output logic      [ncp_pkg::NCP_RESP_W-1:0]    response_cycles_o,
  output logic      [7:0]                        node_id_o,
  output logic      [7:0]                        tentative_id_o,
  output logic      [7:0]                        setup1_o,
  output logic      [7:0]                        setup2_o,
  // Line pins
  output logic                                   line_pulse_a_n_o,
  output logic                                   line_pulse_b_n_o,
  output logic                                   tx_driver_pin_n_o
);

  import ncp_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic                  ack;
    logic [NCP_WB_DW-1:0]  rdata;
    logic                  read_direction_select;
    logic                  pointer_step_enable;
    logic [NCP_RAM_AW-1:0] ptr_addr;
    logic                  indirect_select_msb;
    logic [1:0]            indirect_select_low;
    logic                  soft_rst;
    logic                  cmd_chain_enable;
    logic                  tx_drive_enable;
    logic                  timeout_ext_a;
    logic                  timeout_ext_b;
    logic                  line_drv;
    logic [7:0]            tent_id;
    logic [7:0]            node_id;
    logic [7:0]            setup1;
    logic [7:0]            setup2;
    logic [7:0]            next_id;
    logic [7:0]            status;
    logic [7:0]            diag;
    logic [7:0]            prefetch;
    ncp_fetch_t            fetch;
    logic                  pulse_a_n;
    logic                  pulse_b_n;
    logic                  tx_pin_n;
    logic [NCP_RESP_W-1:0] resp;
  } ncp_state_t;

  ncp_state_t st;
  ncp_state_t next_st;

  logic                  mem_we;
  logic                  mem_rd;
  logic [NCP_RAM_AW-1:0] mem_addr;
  logic [NCP_RAM_DW-1:0] mem_wdata;
  logic [NCP_RAM_DW-1:0] mem_rdata;

  // ==========================================================================
  // Packet memory
  ncp_ram #(
    .AW (NCP_RAM_AW),
    .DW (NCP_RAM_DW)
  ) u_ram (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .rd_i    (mem_rd),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic       req;
    logic       wr;
    logic [2:0] sel;
    logic [7:0] wbyte;
    req   = 1'b0;
    wr    = 1'b0;
    sel   = 3'h0;
    wbyte = 8'h00;

    next_st   = st;
    next_st.ack = 1'b0;
    mem_we    = 1'b0;
    mem_rd    = 1'b0;
    mem_addr  = st.ptr_addr;
    mem_wdata = wb_dat_i[NCP_RAM_DW-1:0];

    // Holding off while ack stands stops one long strobe being taken twice
    req   = wb_cyc_i & wb_stb_i & ~st.ack;
    // Writes need the low byte lane; the other lanes carry nothing here
    wr    = wb_we_i & wb_sel_i[0];
    wbyte = wb_dat_i[7:0];
    sel   = {st.indirect_select_msb, st.indirect_select_low};

    // Prefetch sequencer; the memory is not shared with a bus access meanwhile
    case (st.fetch)
      NCP_FETCH_ISSUE: begin
        mem_rd        = 1'b1;
        next_st.fetch = NCP_FETCH_CATCH;
      end
      NCP_FETCH_CATCH: begin
        next_st.prefetch = mem_rdata;
        next_st.fetch    = NCP_FETCH_IDLE;
      end
      default: begin
        next_st.fetch = NCP_FETCH_IDLE;
      end
    endcase

    // Requests wait while a prefetch runs, so a data read returns the byte of the last finished prefetch
    if (req && st.fetch == NCP_FETCH_IDLE) begin
      next_st.ack   = 1'b1;
      next_st.rdata = '0;
      case (wb_adr_i)
        NCP_ADR_DATA: begin
          if (wb_we_i) begin
            // In read direction a data write is dropped but still steps
            mem_we = wb_sel_i[0] & ~st.read_direction_select;
          end else begin
            next_st.rdata[7:0] = st.prefetch;
          end
          if (st.pointer_step_enable) begin
            // Stepping past the top address wraps to zero
            next_st.ptr_addr = st.ptr_addr + NCP_RAM_AW'(1);
          end
          if (st.read_direction_select && !wb_we_i) begin
            next_st.fetch = NCP_FETCH_ISSUE;
          end
        end
        NCP_ADR_PTR_HI: begin
          if (wr) begin
            next_st.read_direction_select = wbyte[NCP_PH_READ];
            next_st.pointer_step_enable   = wbyte[NCP_PH_STEP];
            next_st.ptr_addr[NCP_RAM_AW-1:8] = wbyte[NCP_PH_UP_MSB:0];
            if (wbyte[NCP_PH_READ]) begin
              next_st.fetch = NCP_FETCH_ISSUE;
            end
          end
          next_st.rdata[NCP_PH_READ]      = st.read_direction_select;
          next_st.rdata[NCP_PH_STEP]      = st.pointer_step_enable;
          next_st.rdata[NCP_PH_UP_MSB:0]  = st.ptr_addr[NCP_RAM_AW-1:8];
        end
        NCP_ADR_PTR_LO: begin
          if (wr) begin
            next_st.ptr_addr[7:0] = wbyte;
            if (st.read_direction_select) begin
              next_st.fetch = NCP_FETCH_ISSUE;
            end
          end
          next_st.rdata[7:0] = st.ptr_addr[7:0];
        end
        NCP_ADR_SEL: begin
          if (wr) begin
            next_st.indirect_select_msb = wbyte[NCP_SEL_MSB];
            next_st.indirect_select_low = wbyte[1:0];
          end
          next_st.rdata[NCP_SEL_MSB:0] = sel;
        end
        NCP_ADR_CFG: begin
          if (wr) begin
            next_st.soft_rst            = wbyte[NCP_CF_SRST];
            next_st.cmd_chain_enable    = wbyte[NCP_CF_CHAIN];
            next_st.tx_drive_enable     = wbyte[NCP_CF_TX_DRIVE_ENABLE];
            next_st.timeout_ext_a       = wbyte[NCP_CF_ET_MSB];
            next_st.timeout_ext_b       = wbyte[NCP_CF_ET_LSB];
            next_st.line_drv            = wbyte[NCP_CF_LDRV];
            next_st.indirect_select_low = wbyte[1:0];
            next_st.indirect_select_msb = 1'b0;
          end
          next_st.rdata[NCP_CF_SRST]   = st.soft_rst;
          next_st.rdata[NCP_CF_CHAIN]  = st.cmd_chain_enable;
          next_st.rdata[NCP_CF_TX_DRIVE_ENABLE]   = st.tx_drive_enable;
          next_st.rdata[NCP_CF_ET_MSB] = st.timeout_ext_a;
          next_st.rdata[NCP_CF_ET_LSB] = st.timeout_ext_b;
          next_st.rdata[NCP_CF_LDRV]   = st.line_drv;
          next_st.rdata[1:0]           = st.indirect_select_low;
        end
        NCP_ADR_IND: begin
          // Reserved select codes read zero and drop writes
          case (sel)
            NCP_IND_TENT: begin
              if (wr) begin
                next_st.tent_id = wbyte;
              end
              next_st.rdata[7:0] = st.tent_id;
            end
            NCP_IND_NODE: begin
              if (wr) begin
                next_st.node_id = wbyte;
              end
              next_st.rdata[7:0] = st.node_id;
            end
            NCP_IND_SET1: begin
              if (wr) begin
                next_st.setup1 = wbyte;
              end
              next_st.rdata[7:0] = st.setup1;
            end
            NCP_IND_NEXT: begin
              next_st.rdata[7:0] = st.next_id;
            end
            NCP_IND_SET2: begin
              if (wr) begin
                next_st.setup2 = wbyte;
              end
              next_st.rdata[7:0] = st.setup2;
            end
            default: begin
              next_st.rdata = '0;
            end
          endcase
        end
        NCP_ADR_STAT: begin
          next_st.rdata[7:0] = st.status;
        end
        NCP_ADR_DIAG: begin
          next_st.rdata[7:0] = st.diag;
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end

    // Engine-owned registers; soft reset holds them cleared, nothing else
    if (st.soft_rst) begin
      next_st.next_id = NCP_BYTE_RST;
      next_st.status  = NCP_BYTE_RST;
      next_st.diag    = NCP_BYTE_RST;
    end else begin
      if (next_id_load_i) begin
        next_st.next_id = next_id_i;
      end
      next_st.status = status_i;
      next_st.diag   = diag_i;
    end

    // Line pins are low-active; the second pulse is ungated in line-driver mode
    next_st.pulse_a_n = ~(tx_pulse_a_i & st.tx_drive_enable);
    next_st.pulse_b_n = ~(tx_pulse_b_i & (st.tx_drive_enable | st.line_drv));
    next_st.tx_pin_n  = ~(tx_drive_i & st.tx_drive_enable);

    // Only the selected figure leaves here; the engine's timer counts it
    case ({st.timeout_ext_a, st.timeout_ext_b})
      2'h0: next_st.resp = RESP_CYC_0;
      2'h1: next_st.resp = RESP_CYC_1;
      2'h2: next_st.resp = RESP_CYC_2;
      2'h3: next_st.resp = RESP_CYC_3;
      default: next_st.resp = RESP_CYC_0;
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st                       <= '0;
      st.ptr_addr              <= NCP_PTR_RST;
      st.tent_id               <= NCP_BYTE_RST;
      st.node_id               <= NCP_BYTE_RST;
      st.setup1                <= NCP_BYTE_RST;
      st.setup2                <= NCP_BYTE_RST;
      st.tx_drive_enable       <= 1'b0;
      st.fetch                 <= NCP_FETCH_IDLE;
      // Pins come up inactive so the line stays quiet until transmit or line-driver mode is enabled
      st.pulse_a_n             <= 1'b1;
      st.pulse_b_n             <= 1'b1;
      st.tx_pin_n              <= 1'b1;
      st.resp                  <= RESP_CYC_0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign wb_ack_o           = st.ack;
  // Read data stays until the next answer replaces it
  assign wb_dat_o           = st.rdata;
  assign soft_reset_o       = st.soft_rst;
  assign cmd_chain_enable_o = st.cmd_chain_enable;
  assign line_driver_mode_o = st.line_drv;
  assign response_cycles_o  = st.resp;
  assign node_id_o          = st.node_id;
  assign tentative_id_o     = st.tent_id;
  assign setup1_o           = st.setup1;
  assign setup2_o           = st.setup2;
  assign line_pulse_a_n_o   = st.pulse_a_n;
  assign line_pulse_b_n_o   = st.pulse_b_n;
  assign tx_driver_pin_n_o  = st.tx_pin_n;

endmodule

// ===== tb/ncp_host.sv
// Host model: classic Wishbone master whose cycles the bench starts
module ncp_host (
  // Clock
  input  wire logic        clk_i,
  // Bus
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  // ==========================================================================
  // One cycle; released data shows the inverse so stale bytes never match
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~d;
  endtask
endmodule

// ===== tb/ncp_regs_chk.sv
// Concurrent checks on the bus answer and configuration outputs
module ncp_regs_chk
  import ncp_pkg::*;
#(
  parameter logic [ncp_pkg::NCP_RESP_W-1:0] RESP_CYC_0 = '0,
  parameter logic [ncp_pkg::NCP_RESP_W-1:0] RESP_CYC_1 = '0,
  parameter logic [ncp_pkg::NCP_RESP_W-1:0] RESP_CYC_2 = '0,
  parameter logic [ncp_pkg::NCP_RESP_W-1:0] RESP_CYC_3 = '0
) (
  // Clock and reset
  input wire logic                           clk_i,
  input wire logic                           rst_i,
  // Bus
  input wire logic                           wb_cyc_i,
  input wire logic                           wb_stb_i,
  input wire logic                           wb_we_i,
  input wire logic [ncp_pkg::NCP_WB_AW-1:0]  wb_adr_i,
  input wire logic [3:0]                     wb_sel_i,
  input wire logic [ncp_pkg::NCP_WB_DW-1:0]  wb_dat_i,
  input wire logic                           wb_ack_o,
  // Configuration and pins
  input wire logic                           soft_reset_o,
  input wire logic                           cmd_chain_enable_o,
  input wire logic                           line_driver_mode_o,
  input wire logic [ncp_pkg::NCP_RESP_W-1:0] response_cycles_o,
  input wire logic                           line_pulse_a_n_o,
  input wire logic                           line_pulse_b_n_o,
  input wire logic                           tx_driver_pin_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Shadow of transmit enable, taken from accepted configuration writes
  logic       txs;
  wire  [7:0] wd = wb_dat_i[7:0];
  wire        cfg_wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
                       && (wb_adr_i == NCP_ADR_CFG);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txs <= 1'b0;
    end else if (cfg_wr) begin
      txs <= wd[5];
    end
  end
  function automatic logic [NCP_RESP_W-1:0] rsp(input logic [1:0] c);
    return (c == 2'h0) ? RESP_CYC_0 : (c == 2'h1) ? RESP_CYC_1 :
           (c == 2'h2) ? RESP_CYC_2 : RESP_CYC_3;
  endfunction
  // ==========================================================================
  // Assertions
  srst_follow_a: assert property (cfg_wr |=> soft_reset_o == $past(wd[7]))
    else $error("soft reset does not follow the written bit");
  srst_hold_a: assert property (!cfg_wr |-> $stable(soft_reset_o))
    else $error("soft reset moved without a configuration write");
  chain_follow_a: assert property (cfg_wr |=> cmd_chain_enable_o == $past(wd[6]))
    else $error("chaining enable does not follow the written bit");
  ldrv_follow_a: assert property (cfg_wr |=> line_driver_mode_o == $past(wd[2]))
    else $error("line driver mode does not follow the written bit");
  resp_sel_a: assert property (cfg_wr |=> response_cycles_o == rsp($past(wd[4:3])))
    else $error("response time does not match the timeout code");
  resp_hold_a: assert property (!cfg_wr |=> $stable(response_cycles_o))
    else $error("response time moved without a configuration write");
  tx_quiet_a: assert property (!txs && !$past(txs) |-> line_pulse_a_n_o &&
      tx_driver_pin_n_o && (line_pulse_b_n_o || line_driver_mode_o || $past(line_driver_mode_o)))
    else $error("line pins active while transmit is disabled");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  cover property (cfg_wr && wd[7]);
  cover property (wb_ack_o && !wb_we_i);
  cover property (!tx_driver_pin_n_o);
endmodule

bind ncp_regs ncp_regs_chk #(
  .RESP_CYC_0(RESP_CYC_0), .RESP_CYC_1(RESP_CYC_1),
  .RESP_CYC_2(RESP_CYC_2), .RESP_CYC_3(RESP_CYC_3)
) i_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .soft_reset_o, .cmd_chain_enable_o, .line_driver_mode_o, .response_cycles_o,
  .line_pulse_a_n_o, .line_pulse_b_n_o, .tx_driver_pin_n_o
);

// ===== tb/test_ncp_regs.sv
// Self-checking bench for the pointer, select and configuration registers
`define CHK(x, y) begin cmp_count++; if ((x) !== (y)) begin errors++; \
  $display("BAD %0t got %h want %h", $time, (x), (y)); end end
module test_ncp_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import ncp_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        tx_pulse_a_i, tx_pulse_b_i, tx_drive_i, next_id_load_i;
  logic [7:0]  next_id_i, status_i, diag_i, node_id_o, tentative_id_o, setup1_o, setup2_o;
  logic        soft_reset_o, cmd_chain_enable_o, line_driver_mode_o;
  logic [NCP_RESP_W-1:0] response_cycles_o;
  logic        line_pulse_a_n_o, line_pulse_b_n_o, tx_driver_pin_n_o;
  int          errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  ncp_regs i_dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .tx_pulse_a_i, .tx_pulse_b_i, .tx_drive_i, .next_id_load_i,
    .next_id_i, .status_i, .diag_i, .soft_reset_o, .cmd_chain_enable_o,
    .line_driver_mode_o, .response_cycles_o, .node_id_o, .tentative_id_o, .setup1_o,
    .setup2_o, .line_pulse_a_n_o, .line_pulse_b_n_o, .tx_driver_pin_n_o
  );
  ncp_host i_host (
    .clk_i, .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i),
    .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i)
  );

  // ==========================================================================
  // Bus helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, a, 4'h1, {24'h0, d}, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    i_host.xfer(1'b0, a, 4'h1, 32'h0, q);
    `CHK(q, {24'h0, e})
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rd(NCP_ADR_PTR_HI, 8'h00);
    rd(NCP_ADR_SEL, 8'h00);
    rd(NCP_ADR_CFG, 8'h00);
    `CHK(response_cycles_o, NCP_RESP_W'(NCP_RESP_CYC_0))
    `CHK({line_pulse_a_n_o, line_pulse_b_n_o, tx_driver_pin_n_o}, 3'h7)
  endtask
  task automatic t_ram();
    wr(NCP_ADR_PTR_HI, 8'h47);
    wr(NCP_ADR_PTR_LO, 8'hfe);
    wr(NCP_ADR_DATA, 8'ha1);
    wr(NCP_ADR_DATA, 8'hb2);
    wr(NCP_ADR_DATA, 8'hc3);
    rd(NCP_ADR_PTR_LO, 8'h01);
    rd(NCP_ADR_PTR_HI, 8'h40);
    wr(NCP_ADR_PTR_HI, 8'hc7);
    wr(NCP_ADR_PTR_LO, 8'hfe);
    rd(NCP_ADR_DATA, 8'ha1);
    rd(NCP_ADR_DATA, 8'hb2);
    rd(NCP_ADR_DATA, 8'hc3);
    wr(NCP_ADR_PTR_HI, 8'h87);
    wr(NCP_ADR_PTR_LO, 8'hff);
    wr(NCP_ADR_DATA, 8'h55);
    rd(NCP_ADR_DATA, 8'hb2);
    rd(NCP_ADR_DATA, 8'hb2);
  endtask
  task automatic t_ind();
    logic [7:0] want;
    for (int c = 0; c < 8; c++) begin
      wr(NCP_ADR_SEL, 8'(c));
      wr(NCP_ADR_IND, 8'h30 + 8'(c));
      want = (c == 3) ? 8'h5a : (c > 4) ? 8'h00 : 8'h30 + 8'(c);
      rd(NCP_ADR_IND, want);
    end
    `CHK({tentative_id_o, node_id_o, setup1_o, setup2_o}, 32'h30313234)
  endtask
  task automatic t_share();
    logic [31:0] q;
    wr(NCP_ADR_SEL, 8'h06);
    rd(NCP_ADR_CFG, 8'h02);
    wr(NCP_ADR_SEL, 8'h07);
    wr(NCP_ADR_CFG, 8'h01);
    rd(NCP_ADR_SEL, 8'h01);
    i_host.xfer(1'b1, NCP_ADR_CFG, 4'he, 32'h000000ff, q);
    rd(NCP_ADR_CFG, 8'h01);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
  endtask
  task automatic t_cfg();
    logic [NCP_RESP_W-1:0] tbl [4];
    logic [7:0] v;
    tbl = '{NCP_RESP_W'(NCP_RESP_CYC_0), NCP_RESP_W'(NCP_RESP_CYC_1),
            NCP_RESP_W'(NCP_RESP_CYC_2), NCP_RESP_W'(NCP_RESP_CYC_3)};
    for (int e = 0; e < 4; e++) begin
      v = {1'b0, e[0], 1'b0, e[1:0], e[1], 2'h0};
      wr(NCP_ADR_CFG, v);
      @(negedge clk_i);
      `CHK(response_cycles_o, tbl[e])
      `CHK(cmd_chain_enable_o, e[0])
      `CHK(line_driver_mode_o, e[1])
      rd(NCP_ADR_CFG, v);
    end
    wr(NCP_ADR_CFG, 8'h00);
  endtask
  task automatic t_srst();
    wr(NCP_ADR_CFG, 8'he3);
    rd(NCP_ADR_STAT, 8'h00);
    rd(NCP_ADR_DIAG, 8'h00);
    rd(NCP_ADR_IND, 8'h00);
    rd(NCP_ADR_CFG, 8'he3);
    rd(NCP_ADR_PTR_HI, 8'h87);
    `CHK(soft_reset_o, 1'b1)
    wr(NCP_ADR_CFG, 8'h63);
    rd(NCP_ADR_STAT, 8'h3c);
    rd(NCP_ADR_DIAG, 8'h99);
  endtask
  task automatic t_line();
    wr(NCP_ADR_CFG, 8'h00);
    tx_pulse_a_i <= 1'b1;
    tx_pulse_b_i <= 1'b1;
    tx_drive_i <= 1'b1;
    settle();
    `CHK({line_pulse_a_n_o, line_pulse_b_n_o, tx_driver_pin_n_o}, 3'h7)
    wr(NCP_ADR_CFG, 8'h04);
    settle();
    `CHK({line_pulse_a_n_o, line_pulse_b_n_o, tx_driver_pin_n_o}, 3'h5)
    wr(NCP_ADR_CFG, 8'h20);
    settle();
    `CHK({line_pulse_a_n_o, line_pulse_b_n_o, tx_driver_pin_n_o}, 3'h0)
  endtask

  // ==========================================================================
  // Run control
  task automatic summarize();
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    rst_i = 1'b1;
    {tx_pulse_a_i, tx_pulse_b_i, tx_drive_i, next_id_load_i} = '0;
    next_id_i = 8'h5a;
    status_i = 8'h3c;
    diag_i = 8'h99;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    next_id_load_i <= 1'b1;
    @(posedge clk_i);
    next_id_load_i <= 1'b0;
    t_reset();
    t_ram();
    t_ind();
    t_share();
    t_cfg();
    t_srst();
    t_line();
    summarize();
  end
endmodule
